// ---- design/crl_pkg.sv ----
// Constants shared by the counter read-back and latch logic
//
// Operation
// - Control byte with bits 5:4 zero latches
// - Read-back select bits pick counters zero-two
// - Output latch holds count until fully read
// - Latching never disturbs mode or counting
// - Repeat count latch ignored while latched
// - Read and write byte order tracked separately
// - Read-back count bit low latches counts
// - Read-back status bit low latches status
// - Status top bits: output pin, pending load
// - Status low six bits echo mode word
// - Pending load set by write, cleared on transfer
// - Two-byte format sets pending on high byte
// - Reads show counting element, not new count
// - Repeat status latch ignored while latched
// - Status read first, then count, then live
// - Strobe and port decode, else bus released
// - Format picks low, high or low-then-high
// - Binary or decimal encoding passes through latch
package crl_pkg;

  // ----------------------------------------------------------------
  // Port codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CRL_PORT_ZERO    = 2'h0;
  localparam logic [1:0] CRL_PORT_ONE     = 2'h1;
  localparam logic [1:0] CRL_PORT_TWO     = 2'h2;
  localparam logic [1:0] CRL_PORT_COMMAND = 2'h3;

  // ----------------------------------------------------------------
  // Command byte fields
  // ----------------------------------------------------------------
  localparam int CRL_PICK_HI       = 7;
  localparam int CRL_PICK_LO       = 6;
  localparam int CRL_ACCESS_HI     = 5;
  localparam int CRL_ACCESS_LO     = 4;
  localparam int CRL_RB_COUNT_N    = 5;
  localparam int CRL_RB_STATUS_N   = 4;
  localparam int CRL_RB_SEL_BASE   = 1;
  localparam logic [1:0] CRL_PICK_READBACK = 2'h3;
  localparam logic [1:0] CRL_ACCESS_LATCH  = 2'h0;

  // ----------------------------------------------------------------
  // Byte formats held in mode word bits 5:4
  // ----------------------------------------------------------------
  localparam logic [1:0] CRL_FMT_LOW  = 2'h1;
  localparam logic [1:0] CRL_FMT_HIGH = 2'h2;
  localparam logic [1:0] CRL_FMT_BOTH = 2'h3;
  localparam int CRL_MODE_FMT_HI = 5;
  localparam int CRL_MODE_FMT_LO = 4;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam int CRL_COUNTERS   = 3;
  localparam int CRL_SYNC_WIDTH = 13;
  localparam logic [5:0]  CRL_MODE_RESET    = 6'h30;
  localparam logic [15:0] CRL_COUNT_RESET   = 16'h0000;
  localparam logic [7:0]  CRL_BYTE_RESET    = 8'h00;

endpackage

// ---- design/crl_sync.sv ----
// Two-flop synchroniser for the bus pins
module crl_sync
  import crl_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage_one;

  // First stage feeds only the second stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage_one <= '1;
      sync_out  <= '1;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule

// ---- design/crl_readback.sv ----
// Counter read path: bus decode, latch commands, read-back, status
module crl_readback
  import crl_pkg::*;
(
  // Clock and reset
  input  wire logic                          clock,
  input  wire logic                          rst_n,
  // Host bus pins
  input  wire logic                          cs_n,
  input  wire logic                          rd_n,
  input  wire logic                          wr_n,
  input  wire logic [1:0]                    port_select,
  input  wire logic [7:0]                    data_in,
  output logic      [7:0]                    data_out,
  output logic                               data_oe,
  // Counting elements
  input  wire logic [CRL_COUNTERS-1:0][15:0] count_element,
  input  wire logic [CRL_COUNTERS-1:0]       timer_out,
  input  wire logic [CRL_COUNTERS-1:0]       load_done,
  // Programming towards the counting elements
  output logic      [CRL_COUNTERS-1:0][15:0] count_register,
  output logic      [CRL_COUNTERS-1:0]       count_written,
  output logic      [CRL_COUNTERS-1:0][5:0]  mode_word,
  output logic      [CRL_COUNTERS-1:0]       control_written,
  output logic      [CRL_COUNTERS-1:0]       pending_load
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [CRL_SYNC_WIDTH-1:0] pins_raw;
  logic [CRL_SYNC_WIDTH-1:0] pins_sync;
  logic [CRL_SYNC_WIDTH-1:0] pins_idle;
  logic                      cs_n_s;
  logic                      rd_n_s;
  logic                      wr_n_s;
  logic [1:0]                sel_s;
  logic [7:0]                din_s;
  logic                      rd_n_prev;
  logic                      wr_n_prev;
  logic                      write_done;
  logic                      read_done;
  logic                      read_active;

  assign pins_raw  = {cs_n, rd_n, wr_n, port_select, data_in};
  assign pins_idle = '1;

  crl_sync #(
    .WIDTH(CRL_SYNC_WIDTH)
  ) u_sync (
    .clock      (clock),
    .rst_n      (rst_n),
    .async_in   (pins_raw),
    .reset_value(pins_idle),
    .sync_out   (pins_sync)
  );

  assign cs_n_s = pins_sync[12];
  assign rd_n_s = pins_sync[11];
  assign wr_n_s = pins_sync[10];
  assign sel_s  = pins_sync[9:8];
  assign din_s  = pins_sync[7:0];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_n_prev <= 1'b1;
      wr_n_prev <= 1'b1;
    end else begin
      rd_n_prev <= rd_n_s;
      wr_n_prev <= wr_n_s;
    end
  end

  // Transfers complete on the trailing edge of the strobe, when data is settled
  assign write_done  = !wr_n_prev && wr_n_s && !cs_n_s && rd_n_s;
  assign read_done   = !rd_n_prev && rd_n_s && !cs_n_s && wr_n_s;
  assign read_active = !cs_n_s && !rd_n_s && wr_n_s
                       && (sel_s != CRL_PORT_COMMAND);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic       cmd_write;
  logic       cmd_is_latch;
  logic       cmd_is_readback;
  logic [1:0] cmd_pick;

  assign cmd_write       = write_done && (sel_s == CRL_PORT_COMMAND);
  assign cmd_pick        = din_s[CRL_PICK_HI:CRL_PICK_LO];
  assign cmd_is_readback = cmd_write && (cmd_pick == CRL_PICK_READBACK);
  assign cmd_is_latch    = cmd_write && !cmd_is_readback
                           && (din_s[CRL_ACCESS_HI:CRL_ACCESS_LO] == CRL_ACCESS_LATCH);

  // Byte of a 16-bit value picked by format and byte order
  function automatic logic [7:0] pick_byte(input logic [15:0] value,
                                           input logic [1:0]  fmt,
                                           input logic        high_next);
    logic [7:0] result;
    result = value[7:0];
    if (fmt == CRL_FMT_HIGH || (fmt == CRL_FMT_BOTH && high_next)) begin
      result = value[15:8];
    end
    return result;
  endfunction

  // Read-back select bit of one counter, shared by count and status latching
  function automatic logic rb_selects(input logic [7:0] cmd,
                                      input int         index);
    logic hit;
    hit = cmd[CRL_RB_SEL_BASE + index];
    return hit;
  endfunction

  // ----------------------------------------------------------------
  // Per-counter state
  // ----------------------------------------------------------------
  logic [CRL_COUNTERS-1:0][7:0] read_byte;

  genvar gi;
  generate
    for (gi = 0; gi < CRL_COUNTERS; gi++) begin : g_counter
      localparam logic [1:0] COUNTER_PORT = 2'(gi);
      logic        this_port;
      logic        ctrl_hit;
      logic        latch_count_req;
      logic        latch_status_req;
      logic        count_latched;
      logic        status_latched;
      logic [15:0] latched_value;
      logic [7:0]  status_value;
      logic        read_high;
      logic        write_high;
      logic [1:0]  fmt;
      logic        data_write;
      logic        count_read;
      logic        set_pending;

      assign this_port = (sel_s == COUNTER_PORT);
      assign fmt       = mode_word[gi][CRL_MODE_FMT_HI:CRL_MODE_FMT_LO];
      assign ctrl_hit  = cmd_write && !cmd_is_readback && !cmd_is_latch
                         && (cmd_pick == COUNTER_PORT);
      assign latch_count_req = (cmd_is_latch && cmd_pick == COUNTER_PORT)
                               || (cmd_is_readback && rb_selects(din_s, gi)
                                   && !din_s[CRL_RB_COUNT_N]);
      assign latch_status_req = cmd_is_readback && rb_selects(din_s, gi)
                                && !din_s[CRL_RB_STATUS_N];
      assign data_write = write_done && this_port;
      assign count_read = read_done && this_port && !status_latched;

      // Mode word store; only the control word touches it, never a latch
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          mode_word[gi]       <= CRL_MODE_RESET;
          control_written[gi] <= 1'b0;
        end else begin
          control_written[gi] <= ctrl_hit;
          if (ctrl_hit) begin
            mode_word[gi] <= din_s[5:0];
          end
        end
      end

      // Count latch: first request wins, held until fully read
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          count_latched <= 1'b0;
          latched_value <= CRL_COUNT_RESET;
        end else if (ctrl_hit) begin
          count_latched <= 1'b0;
        end else if (latch_count_req && !count_latched) begin
          count_latched <= 1'b1;
          latched_value <= count_element[gi];
        end else if (count_read && count_latched
                     && !(fmt == CRL_FMT_BOTH && !read_high)) begin
          count_latched <= 1'b0;
        end
      end

      // Status latch: one byte, cleared when read
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          status_latched <= 1'b0;
          status_value   <= CRL_BYTE_RESET;
        end else if (ctrl_hit) begin
          status_latched <= 1'b0;
        end else if (latch_status_req && !status_latched) begin
          status_latched <= 1'b1;
          status_value   <= {timer_out[gi], pending_load[gi], mode_word[gi]};
        end else if (read_done && this_port && status_latched) begin
          status_latched <= 1'b0;
        end
      end

      // Read byte order, independent of write order
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          read_high <= 1'b0;
        end else if (ctrl_hit) begin
          read_high <= 1'b0;
        end else if (count_read && fmt == CRL_FMT_BOTH) begin
          read_high <= !read_high;
        end
      end

      // Write byte order and count register
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          write_high          <= 1'b0;
          count_register[gi]  <= CRL_COUNT_RESET;
          count_written[gi]   <= 1'b0;
        end else begin
          count_written[gi] <= 1'b0;
          if (ctrl_hit) begin
            write_high <= 1'b0;
          end else if (data_write) begin
            unique case (fmt)
              CRL_FMT_LOW: begin
                count_register[gi] <= {8'h00, din_s};
                count_written[gi]  <= 1'b1;
              end
              CRL_FMT_HIGH: begin
                count_register[gi] <= {din_s, 8'h00};
                count_written[gi]  <= 1'b1;
              end
              CRL_FMT_BOTH: begin
                if (!write_high) begin
                  count_register[gi][7:0] <= din_s;
                  write_high              <= 1'b1;
                end else begin
                  count_register[gi][15:8] <= din_s;
                  write_high               <= 1'b0;
                  count_written[gi]        <= 1'b1;
                end
              end
              default: begin
                write_high <= 1'b0;
              end
            endcase
          end
        end
      end

      // Pending load: setting wins over a simultaneous transfer
      assign set_pending = ctrl_hit || count_written[gi];

      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pending_load[gi] <= 1'b0;
        end else if (set_pending) begin
          pending_load[gi] <= 1'b1;
        end else if (load_done[gi]) begin
          pending_load[gi] <= 1'b0;
        end
      end

      // Byte presented for a read of this counter
      always_comb begin
        if (status_latched) begin
          read_byte[gi] = status_value;
        end else if (count_latched) begin
          read_byte[gi] = pick_byte(latched_value, fmt, read_high);
        end else begin
          read_byte[gi] = pick_byte(count_element[gi], fmt, read_high);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Read byte select
  // ----------------------------------------------------------------
  // Port code three has no counter behind it; the enable keeps it off the bus
  logic [7:0] bus_byte;

  always_comb begin
    bus_byte = CRL_BYTE_RESET;
    unique case (sel_s)
      CRL_PORT_ZERO: begin
        bus_byte = read_byte[0];
      end
      CRL_PORT_ONE: begin
        bus_byte = read_byte[1];
      end
      CRL_PORT_TWO: begin
        bus_byte = read_byte[2];
      end
      CRL_PORT_COMMAND: begin
        bus_byte = CRL_BYTE_RESET;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Data bus drive
  // ----------------------------------------------------------------
  // Registered so the pins see no decode glitches; adds one cycle of latency
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= CRL_BYTE_RESET;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= read_active;
      if (read_active) begin
        data_out <= bus_byte;
      end
    end
  end

endmodule

// ---- tb/crl_host.sv ----
// Host bus model that drives the device pins
module crl_host (
  // Clock
  input  wire logic       clock,
  // Bus pins
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic [1:0]      port_select,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    port_select = 2'h0;
    data_in = 8'h00;
  end

  // --------------------------------------------------------------
  // Accesses
  // --------------------------------------------------------------
  // Write strobe stays low 4 clocks, read strobe 5, both high 6, above the 3 the pins need
  task automatic wr(input logic [1:0] p, input logic [7:0] d, input logic sel = 1'b1);
    @(posedge clock);
    #1 cs_n = !sel;
    port_select = p;
    data_in = d;
    wr_n = 1'b0;
    repeat (4) @(posedge clock);
    #1 wr_n = 1'b1;
    repeat (6) @(posedge clock);
    #1 cs_n = 1'b1;
    // Released bus shows the inverse so a stale byte cannot pass
    data_in = ~d;
  endtask

  task automatic rd(input logic [1:0] p, output logic [7:0] d, output logic oe,
                    input logic sel = 1'b1);
    @(posedge clock);
    #1 cs_n = !sel;
    port_select = p;
    rd_n = 1'b0;
    repeat (5) @(posedge clock);
    #1 d = data_out;
    oe = data_oe;
    rd_n = 1'b1;
    repeat (6) @(posedge clock);
    #1 cs_n = 1'b1;
  endtask
endmodule

// ---- tb/crl_readback_checker.sv ----
// Port assertions for the counter read path
module crl_readback_checker
  import crl_pkg::*;
(
  // Clock and reset
  input wire logic                         clock,
  input wire logic                         rst_n,
  // Host bus
  input wire logic                         cs_n,
  input wire logic                         rd_n,
  input wire logic                         wr_n,
  input wire logic [1:0]                   port_select,
  input wire logic                         data_oe,
  // Counter side
  input wire logic [CRL_COUNTERS-1:0]      load_done,
  input wire logic [CRL_COUNTERS-1:0]      count_written,
  input wire logic [CRL_COUNTERS-1:0][5:0] mode_word,
  input wire logic [CRL_COUNTERS-1:0]      control_written,
  input wire logic [CRL_COUNTERS-1:0]      pending_load
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  chk_oe_on_read: assert property ($rose(data_oe) |-> !$past(rd_n, 2) && !$past(cs_n, 2)
    && $past(port_select, 2) != CRL_PORT_COMMAND) else $error("bus driven without a read");
  chk_oe_rd_idle: assert property (rd_n && $past(rd_n) && $past(rd_n, 2) && $past(rd_n, 3)
    |-> !data_oe) else $error("bus driven with read strobe idle");
  chk_oe_deselect: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) && $past(cs_n, 3)
    |-> !data_oe) else $error("bus driven while deselected");
  chk_oe_fall_cause: assert property ($fell(data_oe) |-> $past(rd_n, 2))
    else $error("bus released during a read");
  chk_count_decode: assert property (|count_written |-> !$past(wr_n, 6) && !$past(cs_n, 6)
    && $past(port_select, 6) != CRL_PORT_COMMAND) else $error("count write without cause");
  chk_ctrl_decode: assert property (|control_written |-> !$past(wr_n, 6)
    && $past(port_select, 6) == CRL_PORT_COMMAND) else $error("control write without cause");
  chk_pend_set: assert property (count_written[0] |-> ##[0:1] pending_load[0])
    else $error("pending flag not set by count write");
  chk_pend_clear: assert property (load_done[2] && !count_written[2] && !control_written[2]
    |=> !pending_load[2]) else $error("pending flag not cleared by load");
  chk_pend_hold: assert property (pending_load[0] && !load_done[0] |=> pending_load[0])
    else $error("pending flag dropped without load");
  chk_mode_cause: assert property (!$stable(mode_word) |-> |control_written)
    else $error("mode word changed without control word");
endmodule

bind crl_readback crl_readback_checker i_crl_readback_checker (.clock, .rst_n, .cs_n, .rd_n,
  .wr_n, .port_select, .data_oe, .load_done, .count_written, .mode_word, .control_written,
  .pending_load);

// ---- tb/crl_readback_tb.sv ----
// Self-checking bench for the counter read path
module crl_readback_tb;
  import crl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic                          clock = 1'b0;
  logic                          rst_n = 1'b0;
  logic                          cs_n, rd_n, wr_n, data_oe;
  logic [1:0]                    port_select;
  logic [7:0]                    data_in, data_out;
  logic [CRL_COUNTERS-1:0][15:0] count_element, count_register;
  logic [CRL_COUNTERS-1:0][5:0]  mode_word;
  logic [CRL_COUNTERS-1:0]       timer_out, load_done, count_written;
  logic [CRL_COUNTERS-1:0]       control_written, pending_load;
  logic [7:0]                    d;
  logic                          oe;
  int                            n_errors = 0;
  int                            checks_done = 0;
  int                            cycles = 0;

  always #25 clock = ~clock;

  crl_host i_crl_host (.clock, .cs_n, .rd_n, .wr_n, .port_select, .data_in, .data_out,
    .data_oe);
  crl_readback i_crl_readback (.clock, .rst_n, .cs_n, .rd_n, .wr_n, .port_select, .data_in,
    .data_out, .data_oe, .count_element, .timer_out, .load_done, .count_register,
    .count_written, .mode_word, .control_written, .pending_load);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic w(input logic [1:0] p, input logic [7:0] v);
    i_crl_host.wr(p, v);
  endtask

  task automatic r(input logic [1:0] p, input logic [7:0] e);
    i_crl_host.rd(p, d, oe);
    chk("bus enable", 16'h1, 16'(oe));
    chk($sformatf("data port %0d", p), 16'(e), 16'(d));
  endtask

  task automatic pulse(input int i);
    load_done[i] = 1'b1;
    @(posedge clock);
    #1 load_done[i] = 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // A full run needs about 500 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      end_of_test();
    end
  end

  // --------------------------------------------------------------
  // Sequence
  // --------------------------------------------------------------
  initial begin
    count_element = {16'h2468, 16'h0987, 16'habcd};
    timer_out = 3'h1;
    load_done = 3'h0;
    repeat (5) @(posedge clock);
    #1 rst_n = 1'b1;
    w(2'h3, 8'h34);
    chk("mode 0", 16'h34, 16'(mode_word[0]));
    chk("pending 0", 16'h1, 16'(pending_load[0]));
    pulse(0);
    chk("pending 0", 16'h0, 16'(pending_load[0]));
    w(2'h0, 8'h12);
    chk("pending 0", 16'h0, 16'(pending_load[0]));
    w(2'h0, 8'h34);
    chk("pending 0", 16'h1, 16'(pending_load[0]));
    chk("count reg 0", 16'h3412, count_register[0]);
    // Count held still while latched, then read live once the latch is emptied
    w(2'h3, 8'h00);
    count_element[0] = 16'h1111;
    w(2'h3, 8'h00);
    r(2'h0, 8'hcd);
    w(2'h0, 8'h55);
    r(2'h0, 8'hab);
    w(2'h0, 8'h66);
    chk("count reg 0", 16'h6655, count_register[0]);
    chk("mode 0", 16'h34, 16'(mode_word[0]));
    r(2'h0, 8'h11);
    r(2'h0, 8'h11);
    pulse(0);
    w(2'h3, 8'hb0);
    count_element[0] = 16'h5a3c;
    w(2'h3, 8'hca);
    timer_out = 3'h4;
    count_element = '0;
    w(2'h3, 8'hc2);
    r(2'h0, 8'hb4);
    r(2'h2, 8'h70);
    r(2'h0, 8'h3c);
    r(2'h0, 8'h5a);
    r(2'h0, 8'h00);
    r(2'h0, 8'h00);
    r(2'h2, 8'h68);
    r(2'h2, 8'h24);
    r(2'h2, 8'h00);
    r(2'h2, 8'h00);
    count_element[2] = 16'h1357;
    w(2'h3, 8'h80);
    w(2'h3, 8'he8);
    count_element[2] = 16'h0000;
    r(2'h2, 8'hf0);
    r(2'h2, 8'h57);
    r(2'h2, 8'h13);
    pulse(2);
    chk("pending 2", 16'h0, 16'(pending_load[2]));
    w(2'h3, 8'h51);
    chk("mode 1", 16'h11, 16'(mode_word[1]));
    w(2'h1, 8'h42);
    chk("count reg 1", 16'h0042, count_register[1]);
    count_element[1] = 16'h0987;
    w(2'h3, 8'hd4);
    count_element[1] = 16'h4321;
    r(2'h1, 8'h87);
    r(2'h1, 8'h21);
    w(2'h3, 8'h00);
    r(2'h0, 8'h00);
    count_element[0] = 16'h7788;
    w(2'h3, 8'h34);
    r(2'h0, 8'h88);
    r(2'h0, 8'h77);
    i_crl_host.rd(2'h3, d, oe);
    chk("bus enable port 3", 16'h0, 16'(oe));
    i_crl_host.rd(2'h0, d, oe, 1'b0);
    chk("bus enable deselected", 16'h0, 16'(oe));
    i_crl_host.wr(2'h3, 8'h70, 1'b0);
    chk("mode 1", 16'h11, 16'(mode_word[1]));
    end_of_test();
  end
endmodule
